//--- hw/sio_pkg.sv
package sio_pkg;

	// ----------------------------------------
	// Clock and serial rates
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned RATE0_HZ = 450_000;
	localparam int unsigned RATE1_HZ = 225_000;
	localparam int unsigned RATE2_HZ = 150_000;
	localparam int unsigned RATE3_HZ = 75_000;
	// Half periods round down, so each rate is never slower than named
	localparam logic [6:0] HALF0 = 7'(CLK_HZ / (2 * RATE0_HZ));
	localparam logic [6:0] HALF1 = 7'(CLK_HZ / (2 * RATE1_HZ));
	localparam logic [6:0] HALF2 = 7'(CLK_HZ / (2 * RATE2_HZ));
	localparam logic [6:0] HALF3 = 7'(CLK_HZ / (2 * RATE3_HZ));

	// ----------------------------------------
	// Register map (word index on the register port)
	// ----------------------------------------
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_TX = 3'h1;
	localparam logic [2:0] ADDR_RX = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [2:0] ADDR_MASK = 3'h4;
	localparam logic [2:0] ADDR_DIR = 3'h5;
	localparam logic [2:0] ADDR_POUT = 3'h6;
	localparam logic [2:0] ADDR_PIN = 3'h7;

	// Control field positions
	localparam int CTRL_W = 10;
	localparam int CTRL_MODE3 = 0;
	localparam int CTRL_LEN8 = 1;
	localparam int CTRL_MSB = 2;
	localparam int CTRL_FALL = 3;
	localparam int CTRL_EXT = 4;
	localparam int CTRL_RATE = 5;
	localparam int CTRL_ODCLK = 7;
	localparam int CTRL_ODDAT = 8;
	localparam int CTRL_SEL = 9;

	// Status bits
	localparam int STAT_DONE = 0;
	localparam int STAT_COLL = 1;

	// Reset values and fixed figures
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam logic [3:0] LEN_SHORT = 4'h4;
	localparam logic [3:0] LEN_LONG = 4'h8;
	localparam logic [3:0] SIO_VECTOR = 4'h4;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FINISH = 2'b11
	} sio_state_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int W = 3
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_regs_t;

	sync_regs_t r_reg;
	sync_regs_t r_next;

	// ----------------------------------------
	// Two stages; only the second stage leaves this module
	// ----------------------------------------
	always_comb
	begin
		r_next.s1 = async_in;
		r_next.s2 = r_reg.s1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign sync_out = r_reg.s2;

endmodule
`default_nettype wire

//--- hw/rate_div.sv
`timescale 1ns/1ns
`default_nettype none

module rate_div (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [1:0] rate_sel,
	output logic tick
);

	typedef struct packed {
		logic [6:0] cnt;
	} div_regs_t;

	div_regs_t r_reg;
	div_regs_t r_next;
	logic [6:0] half;

	// ----------------------------------------
	// Half period counter; tick marks each clock toggle
	// ----------------------------------------
	always_comb
	begin
		case (rate_sel)
			2'b00: half = sio_pkg::HALF0;
			2'b01: half = sio_pkg::HALF1;
			2'b10: half = sio_pkg::HALF2;
			default: half = sio_pkg::HALF3;
		endcase
	end

	assign tick = run && (r_reg.cnt == half - 7'h1);

	// Held at zero while stopped so every transfer starts with a full half period
	always_comb
	begin
		r_next = r_reg;
		if (!run || tick)
			r_next.cnt = 7'h0;
		else
			r_next.cnt = r_reg.cnt + 7'h1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

endmodule
`default_nettype wire

//--- hw/serial_io_unit.sv
// Notes on behaviour
// - Two-wire form shares one data pin; three-wire form splits data out and in.
// - Words are four or eight bits, shifted MSB first or LSB first.
// - Each active clock edge captures input and shifts the next output bit.
// - Clock is one of four internal rates or driven in by the partner.
// - Program selects rising or falling edge as the active shift edge.
// - Clock and data outputs may be open drain, pulling low only.
// - Enabled interrupt rises right after a transfer ends; vector address is four.
// - The three pins are a general port, per-bit direction, unless serial is selected.
`timescale 1ns/1ns
`default_nettype none

module serial_io_unit (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	output logic [3:0] irq_vector,
	output logic busy,
	input wire logic port_four_bit_one_i,
	output logic port_four_bit_one_o,
	output logic port_four_bit_one_oe,
	input wire logic port_four_bit_two_i,
	output logic port_four_bit_two_o,
	output logic port_four_bit_two_oe,
	input wire logic port_four_bit_three_i,
	output logic port_four_bit_three_o,
	output logic port_four_bit_three_oe
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		sio_pkg::sio_state_t state;
		logic [sio_pkg::CTRL_W-1:0] ctrl;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] rx_data;
		logic [3:0] cnt;
		logic sck_lvl;
		logic sck_prev;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [2:0] dir;
		logic [2:0] pout;
		logic [2:0] pin_o;
		logic [2:0] pin_oe;
		logic [15:0] rdata;
		logic irq;
	} sio_regs_t;

	localparam sio_regs_t REGS_RST = '{state: sio_pkg::ST_IDLE, ctrl: sio_pkg::CTRL_RST,
		default: '0};

	sio_regs_t r_reg;
	sio_regs_t r_next;

	logic [2:0] pins_s;
	logic tick;
	logic mode3, len8, msb, fall, ext, od_clk, od_dat, sel;
	logic [1:0] rate;
	logic [3:0] len;
	logic idle_lvl, sck_s, din, out_bit, act_edge, start, coll;
	logic [1:0] clr;

	// ----------------------------------------
	// Pin synchronisers and clock divider
	// ----------------------------------------
	pin_sync #(
		.W(3)
	) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in({port_four_bit_three_i, port_four_bit_two_i, port_four_bit_one_i}),
		.sync_out(pins_s)
	);

	// Divider runs only while an internally clocked transfer is active
	rate_div u_div (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.run(r_reg.state == sio_pkg::ST_RUN && !ext),
		.rate_sel(rate),
		.tick(tick)
	);

	// ----------------------------------------
	// Configuration decode
	// ----------------------------------------
	assign mode3 = r_reg.ctrl[sio_pkg::CTRL_MODE3];
	assign len8 = r_reg.ctrl[sio_pkg::CTRL_LEN8];
	assign msb = r_reg.ctrl[sio_pkg::CTRL_MSB];
	assign fall = r_reg.ctrl[sio_pkg::CTRL_FALL];
	assign ext = r_reg.ctrl[sio_pkg::CTRL_EXT];
	assign rate = r_reg.ctrl[sio_pkg::CTRL_RATE +: 2];
	assign od_clk = r_reg.ctrl[sio_pkg::CTRL_ODCLK];
	assign od_dat = r_reg.ctrl[sio_pkg::CTRL_ODDAT];
	assign sel = r_reg.ctrl[sio_pkg::CTRL_SEL];
	assign len = len8 ? sio_pkg::LEN_LONG : sio_pkg::LEN_SHORT;

	// Clock rests away from the active edge, so the first edge out is active
	assign idle_lvl = fall;
	assign sck_s = pins_s[2];
	// Two-wire form listens on the shared data pin
	assign din = mode3 ? pins_s[0] : pins_s[1];
	assign out_bit = msb ? (len8 ? r_reg.tx[7] : r_reg.tx[3]) : r_reg.tx[0];

	// ----------------------------------------
	// Active edge detection, internal or external clock
	// ----------------------------------------
	always_comb
	begin
		act_edge = 1'b0;
		if (r_reg.state == sio_pkg::ST_RUN && r_reg.cnt < len)
		begin
			if (ext)
				act_edge = fall ? (r_reg.sck_prev && !sck_s) : (!r_reg.sck_prev && sck_s);
			else
				act_edge = tick && (r_reg.sck_lvl == idle_lvl);
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		r_next = r_reg;
		start = 1'b0;
		coll = 1'b0;
		clr = 2'b00;
		r_next.sck_prev = sck_s;

		// Register writes
		if (reg_wr)
		begin
			case (reg_addr)
				sio_pkg::ADDR_CTRL: r_next.ctrl = reg_wdata[sio_pkg::CTRL_W-1:0];
				sio_pkg::ADDR_TX:
				begin
					// A second start while busy is dropped and flagged
					if (r_reg.state == sio_pkg::ST_IDLE)
						start = 1'b1;
					else
						coll = 1'b1;
				end
				sio_pkg::ADDR_STAT: clr = reg_wdata[1:0];
				sio_pkg::ADDR_MASK: r_next.mask = reg_wdata[1:0];
				sio_pkg::ADDR_DIR: r_next.dir = reg_wdata[2:0];
				sio_pkg::ADDR_POUT: r_next.pout = reg_wdata[2:0];
				default: r_next.ctrl = r_reg.ctrl;
			endcase
		end

		// Transfer engine
		case (r_reg.state)
			sio_pkg::ST_IDLE:
			begin
				r_next.sck_lvl = idle_lvl;
				r_next.cnt = 4'h0;
				if (start)
				begin
					r_next.tx = reg_wdata[7:0];
					r_next.rx = 8'h00;
					r_next.state = sio_pkg::ST_RUN;
				end
			end
			sio_pkg::ST_RUN:
			begin
				// Hold the clock at rest once the word is done
				if (tick && (r_reg.cnt != len || r_reg.sck_lvl != idle_lvl))
					r_next.sck_lvl = !r_reg.sck_lvl;
				if (act_edge)
				begin
					// Ones fill in behind, so a shared line is released after an eight-bit or MSB-first word
					r_next.rx = msb ? {r_reg.rx[6:0], din} : {din, r_reg.rx[7:1]};
					r_next.tx = msb ? {r_reg.tx[6:0], 1'b1} : {1'b1, r_reg.tx[7:1]};
					r_next.cnt = r_reg.cnt + 4'h1;
				end
				if (r_reg.cnt == len && (ext || r_reg.sck_lvl == idle_lvl))
					r_next.state = sio_pkg::ST_FINISH;
			end
			sio_pkg::ST_FINISH:
			begin
				// A short LSB-first word arrives in the high nibble
				r_next.rx_data = (len8 || msb) ? r_reg.rx : {4'h0, r_reg.rx[7:4]};
				r_next.state = sio_pkg::ST_IDLE;
			end
			default: r_next.state = sio_pkg::ST_IDLE;
		endcase

		// Sticky status; a new event wins over a clear in the same cycle
		r_next.stat = (r_reg.stat & ~clr);
		if (r_reg.state == sio_pkg::ST_FINISH)
			r_next.stat[sio_pkg::STAT_DONE] = 1'b1;
		if (coll)
			r_next.stat[sio_pkg::STAT_COLL] = 1'b1;
		r_next.irq = |(r_next.stat & r_next.mask);

		// Pin drive: serial function or plain port
		if (sel)
		begin
			r_next.pin_o[0] = 1'b0;
			r_next.pin_oe[0] = 1'b0;
			// Shared two-wire data is always open drain so the partner can answer
			if (od_dat || !mode3)
			begin
				r_next.pin_o[1] = 1'b0;
				r_next.pin_oe[1] = !out_bit;
			end
			else
			begin
				r_next.pin_o[1] = out_bit;
				r_next.pin_oe[1] = 1'b1;
			end
			if (ext)
			begin
				r_next.pin_o[2] = 1'b0;
				r_next.pin_oe[2] = 1'b0;
			end
			// Clock pin leads the data pin by one cycle, so data is stable at the edge
			else if (od_clk)
			begin
				r_next.pin_o[2] = 1'b0;
				r_next.pin_oe[2] = !r_next.sck_lvl;
			end
			else
			begin
				r_next.pin_o[2] = r_next.sck_lvl;
				r_next.pin_oe[2] = 1'b1;
			end
		end
		else
		begin
			r_next.pin_o = r_reg.pout;
			r_next.pin_oe = r_reg.dir;
		end

		// Read data stand only in the cycle after the strobe
		r_next.rdata = 16'h0000;
		if (reg_rd)
		begin
			case (reg_addr)
				sio_pkg::ADDR_CTRL: r_next.rdata = {6'h00, r_reg.ctrl};
				sio_pkg::ADDR_TX: r_next.rdata = {8'h00, r_reg.tx};
				sio_pkg::ADDR_RX: r_next.rdata = {8'h00, r_reg.rx_data};
				sio_pkg::ADDR_STAT: r_next.rdata = {13'h0000, busy, r_reg.stat};
				sio_pkg::ADDR_MASK: r_next.rdata = {14'h0000, r_reg.mask};
				sio_pkg::ADDR_DIR: r_next.rdata = {13'h0000, r_reg.dir};
				sio_pkg::ADDR_POUT: r_next.rdata = {13'h0000, r_reg.pout};
				default: r_next.rdata = {13'h0000, pins_s};
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
			r_reg <= REGS_RST;
		else
			r_reg <= r_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = r_reg.rdata;
	assign irq = r_reg.irq;
	assign irq_vector = sio_pkg::SIO_VECTOR;
	assign busy = (r_reg.state != sio_pkg::ST_IDLE);
	assign port_four_bit_one_o = r_reg.pin_o[0];
	assign port_four_bit_one_oe = r_reg.pin_oe[0];
	assign port_four_bit_two_o = r_reg.pin_o[1];
	assign port_four_bit_two_oe = r_reg.pin_oe[1];
	assign port_four_bit_three_o = r_reg.pin_o[2];
	assign port_four_bit_three_oe = r_reg.pin_oe[2];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_mode_two_line: assert property ($past(sel) && !$past(mode3) |-> !port_four_bit_one_oe)
		else $error("first pin driven in two-wire form");

	a_word_length: assert property (busy |-> r_reg.cnt <= len)
		else $error("bit count passed word length");

	a_edge_shift: assert property (act_edge |=> r_reg.cnt == $past(r_reg.cnt) + 4'h1)
		else $error("active edge did not advance the bit count");

	a_ext_no_drive: assert property ($past(sel) && $past(ext) |-> !port_four_bit_three_oe)
		else $error("clock pin driven with external clock");

	a_idle_clock: assert property (!busy [*2] |-> r_reg.sck_lvl == $past(fall))
		else $error("clock not resting at idle level");

	a_open_drain: assert property ($past(sel) && $past(od_dat) |-> !port_four_bit_two_o)
		else $error("open drain data pin driven high");

	a_done_irq: assert property (r_reg.state == sio_pkg::ST_FINISH && r_reg.mask[0] |=> ##1 irq)
		else $error("no interrupt after transfer end");

	a_gpio_dir: assert property (!$past(sel) |-> r_reg.pin_oe == $past(r_reg.dir))
		else $error("port direction not followed");

	a_busy_span: assert property ($rose(busy) |-> busy [*8])
		else $error("busy dropped too early");

	a_busy_clear: assert property (r_reg.state == sio_pkg::ST_FINISH |=> !busy)
		else $error("busy not cleared after last bit");

	c_long_word: cover property (r_reg.state == sio_pkg::ST_FINISH && len8);
	c_short_lsb: cover property (r_reg.state == sio_pkg::ST_FINISH && !len8 && !msb);
	c_ext_clock: cover property (r_reg.state == sio_pkg::ST_FINISH && ext);
	c_collision: cover property (coll);

endmodule
`default_nettype wire

//--- testbench/sio_peer.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Far-side peripheral on the serial link
// ----------------------------------------
module sio_peer (
	input wire logic sck,
	input wire logic sdo,
	input wire logic fall,
	input wire logic ext,
	input wire logic load,
	input wire logic go,
	input wire logic [7:0] load_val,
	input wire logic [3:0] n_edges,
	output logic dout,
	output logic sck_o,
	output logic sck_oe,
	output logic [7:0] got
);
	logic [7:0] pat;
	logic run_r;
	logic sck_r;

	// Clock rests at the idle level outside frames, driven only in external mode
	assign dout = pat[7];
	assign sck_oe = ext;
	assign sck_o = run_r ? sck_r : fall;

	// Capture on the active edge, move on at the other edge so data is settled
	always @(posedge load or posedge sck or negedge sck)
	begin
		if (load)
		begin
			pat = load_val;
			got = 8'h00;
		end
		else if (sck == !fall)
			got = {got[6:0], sdo};
		else
			pat = {pat[6:0], 1'b1};
	end

	// External clock at 800 ns, started out of phase with the system clock
	initial
	begin
		run_r = 1'b0;
		sck_r = 1'b0;
		pat = 8'h00;
		got = 8'h00;
	end
	always @(posedge go)
	begin
		#137;
		sck_r = fall;
		run_r = 1'b1;
		repeat (n_edges)
		begin
			#400 sck_r = !fall;
			#400 sck_r = fall;
		end
		#400 run_r = 1'b0;
	end
endmodule

`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
	logic ref_clk, reset_n, reg_wr, reg_rd, ld, go, irq, busy, pd, ps, pse;
	logic i1, o1, e1, i2, o2, e2, i3, o3, e3;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, ctrl;
	logic [3:0] irq_vector;
	logic [7:0] pat, pgot;
	int num_errors, n_checks;

	// ----------------------------------------
	// Pin levels: pull-ups on clock and data, peer drives data in
	// ----------------------------------------
	assign i1 = pd;
	assign i2 = (e2 ? o2 : 1'b1) & ((ctrl[9] && !ctrl[0]) ? pd : 1'b1);
	assign i3 = e3 ? o3 : (pse ? ps : 1'b1);

	serial_io_unit serial_io_unit_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq), .irq_vector(irq_vector), .busy(busy),
		.port_four_bit_one_i(i1), .port_four_bit_one_o(o1), .port_four_bit_one_oe(e1),
		.port_four_bit_two_i(i2), .port_four_bit_two_o(o2), .port_four_bit_two_oe(e2),
		.port_four_bit_three_i(i3), .port_four_bit_three_o(o3),
		.port_four_bit_three_oe(e3));
	sio_peer sio_peer_i (.sck(i3), .sdo(i2), .fall(ctrl[3]), .ext(ctrl[4] & ctrl[9]),
		.load(ld), .go(go), .load_val(pat), .n_edges(ctrl[1] ? 4'h8 : 4'h4), .dout(pd),
		.sck_o(ps), .sck_oe(pse), .got(pgot));

	// Clock at 10 MHz
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = !ref_clk;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		begin
			n_checks++;
			if (g !== e)
			begin
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
				num_errors++;
			end
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		begin
			@(posedge ref_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
		end
	endtask

	// Read data stand only in the cycle after the read edge
	task automatic rdc(input logic [2:0] a, input logic [15:0] e);
		begin
			@(posedge ref_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask

	// Bit order as seen on the wire, worked out independently of the design
	function automatic logic [15:0] ordr(input logic [7:0] v, input logic l8, input logic m);
		logic [7:0] r;
		begin
			for (int k = 0; k < 8; k++)
				r[k] = l8 ? v[7 - k] : (k < 4 ? v[3 - k] : 1'b0);
			ordr = m ? (l8 ? {8'h00, v} : {12'h000, v[3:0]}) : {8'h00, r};
		end
	endfunction

	// One whole transfer, judged at the pins, the registers and the interrupt
	task automatic xfer(input logic [15:0] c, input logic [7:0] tx, input logic [7:0] p);
		int n;
		int bc;
		int h;
		begin
			n = 0;
			bc = 0;
			h = c[6:5] == 2'd0 ? sio_pkg::HALF0 : c[6:5] == 2'd1 ? sio_pkg::HALF1 :
				c[6:5] == 2'd2 ? sio_pkg::HALF2 : sio_pkg::HALF3;
			@(posedge ref_clk);
			ctrl <= c;
			wr(sio_pkg::ADDR_CTRL, c);
			@(posedge ref_clk);
			pat <= p;
			ld <= 1'b1;
			@(posedge ref_clk);
			ld <= 1'b0;
			wr(sio_pkg::ADDR_MASK, 16'h0001);
			wr(sio_pkg::ADDR_TX, {8'h00, tx});
			@(posedge ref_clk);
			go <= c[4];
			#1 chk({15'h0000, busy}, 16'h0001);
			while (irq !== 1'b1 && n < 3000)
			begin
				@(posedge ref_clk);
				go <= 1'b0;
				bc += (busy === 1'b1);
				n++;
			end
			#1 chk({15'h0000, irq}, 16'h0001);
			if (!c[4])
				chk(16'(bc >= 2 * (c[1] ? 8 : 4) * h - 2), 16'h0001);
			chk({15'h0000, busy}, 16'h0000);
			chk(c[1] ? {8'h00, pgot} : {12'h000, pgot[3:0]},
				c[0] ? ordr(tx, c[1], c[2]) : {8'h00, p});
			rdc(sio_pkg::ADDR_RX, ordr(c[1] ? p : {4'h0, p[7:4]}, c[1], c[2]));
			rdc(sio_pkg::ADDR_STAT, 16'h0001);
			wr(sio_pkg::ADDR_STAT, 16'h0001);
			@(posedge ref_clk);
			#1 chk({15'h0000, irq}, 16'h0000);
		end
	endtask

	task automatic t_reset;
		begin
			chk({12'h000, irq_vector}, 16'h0004);
			chk({13'h0000, busy, irq, e1 | e2 | e3}, 16'h0000);
			rdc(sio_pkg::ADDR_CTRL, 16'h0000);
			wr(sio_pkg::ADDR_RX, 16'h00ff);
			rdc(sio_pkg::ADDR_RX, 16'h0000);
			$display("test reset done");
		end
	endtask

	// Pins as a general port: two outputs, one input from the peer
	task automatic t_gpio;
		begin
			wr(sio_pkg::ADDR_DIR, 16'h0006);
			wr(sio_pkg::ADDR_POUT, 16'h0006);
			@(posedge ref_clk);
			#1 chk({11'h000, e3, e2, e1, o3, o2}, 16'h001b);
			// Pin levels need two more edges to clear the synchroniser
			repeat (2) @(posedge ref_clk);
			rdc(sio_pkg::ADDR_PIN, 16'h0006);
			wr(sio_pkg::ADDR_POUT, 16'h0000);
			repeat (3) @(posedge ref_clk);
			rdc(sio_pkg::ADDR_PIN, 16'h0000);
			wr(sio_pkg::ADDR_DIR, 16'h0000);
			$display("test gpio done");
		end
	endtask

	// Both word lengths, both orders, both edges and all four rates
	task automatic t_modes;
		begin
			for (int i = 0; i < 4; i++)
				xfer(16'h0201 | 16'((i < 2) << 1) | 16'((i % 2 == 0) << 2) |
					16'((i == 1 || i == 2) << 3) | 16'(i << 5), 8'ha5 + 8'(i * 17),
					8'h3c ^ 8'(i * 5));
			$display("test modes done");
		end
	endtask

	task automatic t_ext;
		begin
			xfer(16'h0217, 8'h69, 8'hc3);
			$display("test external clock done");
		end
	endtask

	// Two-wire receive by sending all ones, open drain on clock and data
	task automatic t_two_wire;
		begin
			xfer(16'h0386, 8'hff, 8'h96);
			$display("test two wire done");
		end
	endtask

	// Start while busy is refused and flagged; mask holds the interrupt back
	task automatic t_collide;
		int n;
		begin
			n = 0;
			wr(sio_pkg::ADDR_MASK, 16'h0000);
			wr(sio_pkg::ADDR_CTRL, 16'h0267);
			wr(sio_pkg::ADDR_TX, 16'h0055);
			wr(sio_pkg::ADDR_TX, 16'h00aa);
			rdc(sio_pkg::ADDR_STAT, 16'h0006);
			while (busy !== 1'b0 && n < 3000)
			begin
				@(posedge ref_clk);
				n++;
			end
			repeat (4) @(posedge ref_clk);
			rdc(sio_pkg::ADDR_STAT, 16'h0003);
			chk({15'h0000, irq}, 16'h0000);
			rdc(sio_pkg::ADDR_TX, 16'h00ff);
			wr(sio_pkg::ADDR_MASK, 16'h0002);
			@(posedge ref_clk);
			#1 chk({15'h0000, irq}, 16'h0001);
			wr(sio_pkg::ADDR_STAT, 16'h0003);
			rdc(sio_pkg::ADDR_STAT, 16'h0000);
			$display("test collision done");
		end
	endtask

	task automatic finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, num_errors);
			if (num_errors == 0 && n_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	// Watchdog well beyond the longest expected run
	initial
	begin
		#4_000_000;
		num_errors++;
		finish_test;
	end

	// Main sequence
	initial
	begin
		num_errors = 0;
		n_checks = 0;
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		ctrl = 16'h0000;
		ld = 1'b0;
		go = 1'b0;
		pat = 8'h00;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		#1 t_reset;
		t_gpio;
		t_modes;
		t_ext;
		t_two_wire;
		t_collide;
		finish_test;
	end
endmodule

`default_nettype wire
